// file: dv/radio_query_assertions.sv
// Checker: busy, reset and select timing at the query block's pins.
// Assumes it is bound onto radio_status_query with its port names.
`timescale 1ns/10ps
module radio_query_assertions #(
    parameter int HOLD_CYCLES = 5
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic chip_select_n,
    input wire logic core_busy,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic busy
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    // Select released, then busy held for a run of cycles
    sequence s_close;
        $rose(chip_select_n);
    endsequence
    sequence s_hold;
        busy [*3];
    endsequence
    property p_reset_busy;
        $fell(srst) |-> busy;
    endproperty
    a_reset_busy: assert property (p_reset_busy) else $error("rst busy");
    property p_core;
        core_busy |=> busy;
    endproperty
    a_core: assert property (p_core) else $error("core busy");
    property p_release;
        $fell(busy) |-> !$past(core_busy) && chip_select_n;
    endproperty
    a_release: assert property (p_release) else $error("busy fall");
    property p_frame_hold;
        s_close |-> ##[1:6] s_hold;
    endproperty
    a_frame_hold: assert property (p_frame_hold) else $error("hold");
    property p_oe_idle;
        chip_select_n [*6] |-> !miso_oe;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("oe idle");
    property p_oe_on;
        !chip_select_n [*6] |-> miso_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("oe on");
    property p_oe_rise;
        $rose(miso_oe) |-> !chip_select_n && !$past(chip_select_n, 2);
    endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("oe rise");
    property p_idle_miso;
        chip_select_n [*8] |-> $stable(miso);
    endproperty
    a_idle_miso: assert property (p_idle_miso) else $error("miso");
endmodule // radio_query_assertions

bind radio_status_query radio_query_assertions #(
    .HOLD_CYCLES(HOLD_CYCLES)
) chk_i (.clock(clock), .srst(srst), .chip_select_n(chip_select_n),
    .core_busy(core_busy), .miso(miso), .miso_oe(miso_oe), .busy(busy));

// file: dv/radio_status_query_tb.sv
// Bench: query frames from the host model, answers checked per byte.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/10ps
`define CHK(what, e, g) begin tests_run++; if ((g) !== (e)) begin \
    fails++; $display("ERROR %s expected %h seen %h", what, e, g); end end
module radio_status_query_tb;
    import radio_query_pkg::*;
    typedef struct {
        logic spread;
        logic [7:0] op;
        int n;
        logic [63:0] exp;
    } row_t;
    logic clock, srst, sclk, mosi, chip_select_n, miso, miso_oe, busy;
    logic spread_mode, core_busy;
    logic [15:0] fault_raise;
    logic [63:0] got;
    chip_state_t chip_state;
    radio_event_t radio_event;
    radio_meas_t radio_meas;
    int fails = 0;
    int tests_run = 0;
    // Status 0x54 is mode 5 and command status 2
    row_t rows [11] = '{
        '{1'b0, 8'h13, 4, 64'h0054200C_00000000},
        '{1'b0, 8'h14, 5, 64'h00541A8C_8C000000},
        '{1'b0, 8'h15, 3, 64'h00547000_00000000},
        '{1'b0, 8'h10, 8, 64'h00540001_00010002},
        '{1'b1, 8'h14, 5, 64'h00548CF4_9A000000},
        '{1'b1, 8'h10, 8, 64'h00540001_00010002},
        '{1'b0, 8'h17, 4, 64'h0054017F_00000000},
        '{1'b0, 8'h07, 3, 64'h00545400_00000000},
        '{1'b0, 8'h17, 4, 64'h00540000_00000000},
        '{1'b0, 8'h00, 7, 64'h00545454_54545400},
        '{1'b0, 8'h10, 8, 64'h00540000_00000000}
    };
    radio_status_query #(.DATA_BUFFER_BASE(16'h0004)) radio_status_query_i (
        .clock(clock), .srst(srst), .sclk(sclk), .mosi(mosi),
        .chip_select_n(chip_select_n), .chip_state(chip_state),
        .radio_event(radio_event), .radio_meas(radio_meas),
        .spread_mode(spread_mode), .core_busy(core_busy),
        .fault_raise(fault_raise), .miso(miso), .miso_oe(miso_oe),
        .busy(busy));
    spi_host_model spi_host_model_i (.clock(clock), .miso(miso),
        .sclk(sclk), .mosi(mosi), .chip_select_n(chip_select_n));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic pulse(input radio_event_t e);
        radio_event = e;
        tick(1);
        radio_event = '0;
        tick(1);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Wait for busy low under a bound, then run one frame
    task automatic frame(input logic [7:0] op, input logic [7:0] fill,
            input int n);
        int k = 0;
        while (busy !== 1'b0 && k < 400) begin
            tick(1);
            k++;
        end
        if (busy !== 1'b0) begin
            fails++;
            $display("ERROR busy wait expected 0 seen %b", busy);
            close_out();
        end else begin
            spi_host_model_i.send_frame(op, fill, n, got);
        end
    endtask
    initial begin
        srst = 1'b1;
        chip_state = '{chip_mode: 3'h5, cmd_status: 3'h2};
        radio_event = '0;
        radio_meas = '{8'h8C, 8'hF4, 8'h9A, 8'h20, 16'h0010};
        spread_mode = 1'b0;
        core_busy = 1'b0;
        fault_raise = '0;
        tick(16);
        `CHK("reset busy", 1'b1, busy)
        `CHK("reset oe", 1'b0, miso_oe)
        srst = 1'b0;
        // One packet: crc, length, two header errors, then packet done
        pulse(13'h1000);
        pulse(13'h0800);
        pulse(13'h0400);
        pulse(13'h0032);
        pulse(13'h0004); // Header error in FSK mode is not counted
        spread_mode = 1'b1;
        pulse(13'h0004); // Header error in spread mode is counted
        spread_mode = 1'b0;
        pulse(13'h0200);
        radio_meas.rssi_now = 8'h70;
        fault_raise = 16'hFFFF;
        tick(1);
        fault_raise = '0;
        // Ordinary queries and clears from the table
        foreach (rows[r]) begin
            spread_mode = rows[r].spread;
            frame(rows[r].op, 8'h00, rows[r].n);
            for (int b = 0; b < rows[r].n; b++) begin
                `CHK("byte", rows[r].exp[63-8*b -: 8], got[63-8*b -: 8])
            end
        end
        core_busy = 1'b1;
        tick(2);
        `CHK("core busy", 1'b1, busy)
        core_busy = 1'b0;
        // Clear with a nonzero parameter leaves the fault word alone
        fault_raise = 16'h0100;
        tick(1);
        fault_raise = '0;
        frame(OP_CLEAR_FAULTS, 8'h01, 3);
        frame(OP_QUERY_FAULTS, 8'h00, 4);
        `CHK("fault kept", 16'h0100, got[47:32])
        srst = 1'b1;
        tick(3);
        `CHK("mid reset busy", 1'b1, busy)
        srst = 1'b0;
        frame(OP_QUERY_FAULTS, 8'h00, 4);
        `CHK("fault after reset", 16'h0000, got[47:32])
        close_out();
    end
endmodule // radio_status_query_tb

// file: dv/spi_host_model.sv
// Host model: mode 0 master sending whole bytes under select.
// Assumes the core clock paces it; serial clock period is 80 ns.
`timescale 1ns/10ps
module spi_host_model (
    input wire logic clock,
    input wire logic miso,
    output logic sclk,
    output logic mosi,
    output logic chip_select_n
);
    initial begin
        sclk = 1'b0;
        mosi = 1'b0;
        chip_select_n = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Opcode first, then parameter or filler bytes, MSB first
    task automatic send_frame(input logic [7:0] op, input logic [7:0] fill,
            input int n, output logic [63:0] got);
        logic [7:0] tx;
        got = '0;
        tick(1);
        chip_select_n = 1'b0;
        tick(8);
        for (int b = 0; b < n; b++) begin
            tx = (b == 0) ? op : fill;
            for (int i = 7; i >= 0; i--) begin
                mosi = tx[i];
                tick(4);
                sclk = 1'b1;
                tick(3);
                got[56 - 8 * b + i] = miso;
                tick(1);
                sclk = 1'b0;
            end
        end
        tick(4);
        chip_select_n = 1'b1;
        mosi = ~mosi; // Released line shows no stale bit
        tick(6); // Let the device see the end and raise busy
    endtask
endmodule // spi_host_model

// file: logic/radio_query_pkg.sv
// Shared constants and carrier types for the status query command block.
// Assumes one 100 MHz core clock and a mode 0 serial link from the host.
package radio_query_pkg;

    // Core clock and least time busy stays high after a frame ends
    localparam int CLK_PERIOD_NS = 10;
    localparam int BUSY_HOLD_NS = 50;
    localparam int BUSY_HOLD_CYCLES =
        (BUSY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Operational command bytes
    localparam logic [7:0] OP_CLEAR_COUNTERS = 8'h00;
    localparam logic [7:0] OP_CLEAR_FAULTS = 8'h07;
    localparam logic [7:0] OP_QUERY_COUNTERS = 8'h10;
    localparam logic [7:0] OP_QUERY_BUFFER = 8'h13;
    localparam logic [7:0] OP_QUERY_QUALITY = 8'h14;
    localparam logic [7:0] OP_QUERY_POWER = 8'h15;
    localparam logic [7:0] OP_QUERY_FAULTS = 8'h17;

    // Byte positions within a frame
    localparam logic [3:0] POS_OPCODE = 4'h0;
    localparam logic [3:0] POS_STATUS = 4'h1;
    localparam logic [3:0] POS_FIELD0 = 4'h2;
    localparam logic [3:0] POS_FIELD5 = 4'h7;
    localparam logic [3:0] POS_FAULT_CLR = 4'h2;
    localparam logic [3:0] POS_COUNT_CLR = 4'h6;
    localparam logic [3:0] POS_MAX = 4'hF;
    localparam int FIELD_BYTES = 6;

    // Filler returned in the opcode position, and the zero parameter value
    localparam logic [7:0] RESERVED_BYTE = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // Fault word bit positions; bit 7 and bits 15:9 stay zero
    localparam int FAULT_SLOW_RC = 0;
    localparam int FAULT_FAST_RC = 1;
    localparam int FAULT_SYNTH_CAL = 2;
    localparam int FAULT_CONV_CAL = 3;
    localparam int FAULT_IMAGE_CAL = 4;
    localparam int FAULT_CRYSTAL = 5;
    localparam int FAULT_SYNTH_LOCK = 6;
    localparam int FAULT_AMP_RAMP = 8;
    localparam logic [15:0] FAULT_MASK = 16'h017F;

    // Running average weight, as a right shift of the error term
    localparam int AVG_SHIFT = 3;
    localparam int AVG_FRAC = 4;

    // Chip state reported in every status byte
    typedef struct packed {
        logic [2:0] chip_mode;
        logic [2:0] cmd_status;
    } chip_state_t;

    // One-cycle events from the receive datapath
    typedef struct packed {
        logic rx_start;
        logic sync_detect;
        logic payload_sample;
        logic pkt_done;
        logic preamble_err;
        logic sync_err;
        logic addr_err;
        logic crc_err;
        logic length_err;
        logic abort_err;
        logic header_err;
        logic pkt_received;
        logic pkt_sent;
    } radio_event_t;

    // Measurements from the receive datapath
    typedef struct packed {
        logic [7:0] rssi_now;
        logic [7:0] spread_snr;
        logic [7:0] spread_signal;
        logic [7:0] payload_length;
        logic [15:0] payload_start_addr;
    } radio_meas_t;

endpackage

// file: logic/radio_status_query.sv
// Status and diagnostics query command decoder of the radio transceiver.
// Assumes the receive datapath and chip core run on clock; host pins
// arrive asynchronously and are synchronised in the byte engine.
//
// Summary of operation
// RL1: Buffer query returns status, last payload length, payload start.
// RL2: Payload start is an offset from the data buffer's first byte.
// RL3: Quality query returns status and three packet-type dependent bytes.
// RL4: FSK flag byte: preamble, sync, address, CRC, length, abort, rx, tx.
// RL5: Sync power latched at sync detect, negated half-dB units.
// RL6: Payload power average latched at packet done, same encoding.
// RL7: Spread mode packet power is average over last packet, half-dB.
// RL8: SNR is two's complement, quarter-dB steps.
// RL9: Despread signal power reported negated in half-dB steps.
// RL10: Instant power query returns status then current power.
// RL11: Counter query returns three 16-bit counters, MSB first.
// RL12: Spread mode third counter counts header failures.
// RL13: Opcode zero plus six zero bytes clears all counters.
// RL14: Fault query returns status then 16-bit fault word.
// RL15: Fault bits 0-6 calibration/start/lock, bit 8 ramp, rest zero.
// RL16: Fault clear with two zero bytes clears all; status on both.
// RL17: First byte is the opcode; parameters decoded per opcode.
// RL18: Busy pin shows whether a command can be accepted.
// RL19: Active-low chip select frames each transfer of 8-bit words.
// RL20: Status byte: chip mode in 6:4, command status in 3:1.
// RL21: Status shifts out while command bytes are received.
// RL22: Host sends filler bytes when reading and waits on busy.
// RL23: Byte 0 of every answer is a reserved value.
`timescale 1ns/10ps
module radio_status_query #(
    parameter logic [15:0] DATA_BUFFER_BASE = 16'h0000,
    parameter int HOLD_CYCLES = radio_query_pkg::BUSY_HOLD_CYCLES
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic chip_select_n,
    input wire radio_query_pkg::chip_state_t chip_state,
    input wire radio_query_pkg::radio_event_t radio_event,
    input wire radio_query_pkg::radio_meas_t radio_meas,
    input wire logic spread_mode,
    input wire logic core_busy,
    input wire logic [15:0] fault_raise,
    output logic miso,
    output logic miso_oe,
    output logic busy
);
    import radio_query_pkg::*;

    // Fixed-point running average step, used for each payload sample after the first
    function automatic logic [11:0] avg_step(input logic [11:0] acc,
                                             input logic [7:0] sample);
        logic [12:0] diff;
        logic [12:0] step;
        diff = {1'b0, sample, 4'h0} - {1'b0, acc};
        step = $signed(diff) >>> AVG_SHIFT;
        return 12'(acc + step[11:0]);
    endfunction

    // Byte engine outputs and the byte it sends next
    logic frame_start;
    logic frame_end;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;

    // Frame decode state
    logic [3:0] pos_q;
    logic [7:0] opcode_q;
    logic all_zero_q;
    logic param_zero_q;
    logic [FIELD_BYTES-1:0][7:0] field_q;

    // Receive quality state
    logic [7:0] fsk_receive_flags_q;
    logic [7:0] sync_power_latched_q;
    logic [11:0] avg_acc_q;
    logic avg_first_q;
    logic [7:0] payload_power_average_q;
    logic [7:0] packet_snr_quarter_db_q;
    logic [7:0] despread_signal_power_q;
    logic [7:0] last_payload_length_q;
    logic [7:0] payload_start_offset_q;

    // Fault word, counter clears and busy
    logic [15:0] fault_word_q;
    logic clear_counters_q;
    logic clear_faults_q;
    logic [7:0] hold_q;
    logic busy_q;

    // Counter values
    logic [15:0] received_packet_count;
    logic [15:0] crc_fail_count;
    logic [15:0] third_fail_count;

    spi_byte_link u_link (
        .clock(clock),
        .srst(srst),
        .sclk(sclk),
        .mosi(mosi),
        .chip_select_n(chip_select_n), // [RL19]
        .tx_byte(tx_byte),
        .frame_start(frame_start),
        .frame_end(frame_end),
        .rx_valid(rx_valid),
        .rx_byte(rx_byte),
        .miso(miso),
        .miso_oe(miso_oe)
    );

    // Status byte: reserved bits 7 and 0 read zero
    wire [7:0] status_byte = {1'b0, chip_state.chip_mode,
                              chip_state.cmd_status, 1'b0}; // [RL20]

    // Frame position decode
    wire at_opcode = rx_valid && (pos_q == POS_OPCODE); // [RL17]
    wire rx_zero = (rx_byte == ZERO_BYTE);
    wire in_fields = (pos_q >= POS_FIELD0) && (pos_q <= POS_FIELD5);
    // Byte 2 is the top byte of the snapshot, byte 7 the bottom one
    wire [2:0] field_idx = 3'(POS_FIELD5 - pos_q);

    // Parameter checks of the two clearing commands
    wire hit_clear_counters = rx_valid && (pos_q == POS_COUNT_CLR)
                            && all_zero_q && rx_zero; // [RL13]
    wire hit_clear_faults = rx_valid && (pos_q == POS_FAULT_CLR)
                          && (opcode_q == OP_CLEAR_FAULTS)
                          && param_zero_q && rx_zero; // [RL16]

    // Byte sent next: reserved, status, then snapshot fields
    assign tx_byte = (pos_q == POS_OPCODE) ? RESERVED_BYTE // [RL23]
                   : (pos_q == POS_STATUS) ? status_byte // [RL21]
                   : in_fields ? field_q[field_idx]
                   : status_byte;

    // Answer fields per opcode, captured as the opcode completes
    wire [47:0] fill_status = {FIELD_BYTES{status_byte}};
    wire [47:0] buffer_fields = {last_payload_length_q,
                                 payload_start_offset_q,
                                 fill_status[31:0]}; // [RL1]
    wire [47:0] fsk_fields = {fsk_receive_flags_q,
                              sync_power_latched_q,
                              payload_power_average_q,
                              fill_status[23:0]};
    wire [47:0] spread_fields = {payload_power_average_q, // [RL7]
                                 packet_snr_quarter_db_q, // [RL8]
                                 despread_signal_power_q, // [RL9]
                                 fill_status[23:0]};
    wire [47:0] quality_fields = spread_mode ? spread_fields
                                             : fsk_fields; // [RL3]
    wire [47:0] power_fields = {radio_meas.rssi_now,
                                fill_status[39:0]}; // [RL10]
    wire [47:0] counter_fields = {received_packet_count,
                                  crc_fail_count,
                                  third_fail_count}; // [RL11]
    wire [47:0] fault_fields = {fault_word_q,
                                fill_status[31:0]}; // [RL14]
    wire [47:0] fields_d =
        (rx_byte == OP_QUERY_BUFFER) ? buffer_fields
      : (rx_byte == OP_QUERY_QUALITY) ? quality_fields
      : (rx_byte == OP_QUERY_POWER) ? power_fields
      : (rx_byte == OP_QUERY_COUNTERS) ? counter_fields
      : (rx_byte == OP_QUERY_FAULTS) ? fault_fields
      : fill_status; // Clear and unknown opcodes answer status

    // Position counter saturates so long frames keep answering status
    wire [3:0] pos_next = (pos_q == POS_MAX) ? pos_q : pos_q + 4'h1;

    // Frame tracking and answer snapshot
    always_ff @(posedge clock) begin
        if (srst) begin
            pos_q <= POS_OPCODE;
            opcode_q <= 8'h00;
            all_zero_q <= 1'b0;
            param_zero_q <= 1'b0;
            field_q <= '0;
        end else if (frame_start || frame_end) begin
            pos_q <= POS_OPCODE; // [RL19]
            all_zero_q <= 1'b0;
            param_zero_q <= 1'b0;
        end else if (rx_valid) begin
            pos_q <= pos_next;
            if (at_opcode) begin
                opcode_q <= rx_byte; // [RL17]
                field_q <= fields_d;
                all_zero_q <= rx_zero;
                param_zero_q <= 1'b1;
            end else begin
                all_zero_q <= all_zero_q && rx_zero;
                param_zero_q <= param_zero_q && rx_zero;
            end
        end
    end

    // Clear requests, taken one cycle after the last parameter byte
    always_ff @(posedge clock) begin
        if (srst) begin
            clear_counters_q <= 1'b0;
            clear_faults_q <= 1'b0;
        end else begin
            clear_counters_q <= hit_clear_counters; // [RL13]
            clear_faults_q <= hit_clear_faults; // [RL16]
        end
    end

    // FSK flag byte, bit 7 down to bit 0
    wire [7:0] flag_events = {radio_event.preamble_err,
                              radio_event.sync_err,
                              radio_event.addr_err,
                              radio_event.crc_err,
                              radio_event.length_err,
                              radio_event.abort_err,
                              radio_event.pkt_received,
                              radio_event.pkt_sent}; // [RL4]

    // Flags restart with each reception; a new event wins over restart
    always_ff @(posedge clock) begin
        if (srst) begin
            fsk_receive_flags_q <= 8'h00;
        end else if (radio_event.rx_start) begin
            fsk_receive_flags_q <= flag_events;
        end else begin
            fsk_receive_flags_q <= fsk_receive_flags_q | flag_events;
        end
    end

    // Power at sync detect, already negated half-dB from the datapath
    always_ff @(posedge clock) begin
        if (srst) begin
            sync_power_latched_q <= 8'h00;
        end else if (radio_event.sync_detect) begin
            sync_power_latched_q <= radio_meas.rssi_now; // [RL5]
        end
    end

    // Running average over the payload samples of the current packet
    always_ff @(posedge clock) begin
        if (srst) begin
            avg_acc_q <= 12'h000;
            avg_first_q <= 1'b1;
        end else if (radio_event.rx_start) begin
            avg_first_q <= 1'b1;
        end else if (radio_event.payload_sample) begin
            avg_first_q <= 1'b0;
            avg_acc_q <= avg_first_q ? {radio_meas.rssi_now, 4'h0}
                       : avg_step(avg_acc_q, radio_meas.rssi_now);
        end
    end

    // Offset of the payload start inside the data buffer
    wire [15:0] start_offset = radio_meas.payload_start_addr
                             - DATA_BUFFER_BASE; // [RL2]

    // Packet results captured at packet done
    always_ff @(posedge clock) begin
        if (srst) begin
            payload_power_average_q <= 8'h00;
            packet_snr_quarter_db_q <= 8'h00;
            despread_signal_power_q <= 8'h00;
            last_payload_length_q <= 8'h00;
            payload_start_offset_q <= 8'h00;
        end else if (radio_event.pkt_done) begin
            payload_power_average_q <= avg_acc_q[11:AVG_FRAC]; // [RL6]
            packet_snr_quarter_db_q <= radio_meas.spread_snr; // [RL8]
            despread_signal_power_q <= radio_meas.spread_signal; // [RL9]
            last_payload_length_q <= radio_meas.payload_length; // [RL1]
            payload_start_offset_q <= start_offset[7:0]; // [RL2]
        end
    end

    // Fault word: a raise in the clear cycle survives the clear
    always_ff @(posedge clock) begin
        if (srst) begin
            fault_word_q <= 16'h0000;
        end else begin
            fault_word_q <= (clear_faults_q ? 16'h0000 : fault_word_q)
                          | (fault_raise & FAULT_MASK); // [RL15] [RL16]
        end
    end

    // Third counter source depends on the packet type
    wire third_event = spread_mode ? radio_event.header_err // [RL12]
                                   : radio_event.length_err;

    stat_counter #(.WIDTH(16)) u_received (
        .clock(clock),
        .srst(srst),
        .inc(radio_event.pkt_received),
        .clr(clear_counters_q), // [RL13]
        .count(received_packet_count)
    );

    stat_counter #(.WIDTH(16)) u_crc (
        .clock(clock),
        .srst(srst),
        .inc(radio_event.crc_err),
        .clr(clear_counters_q),
        .count(crc_fail_count)
    );

    stat_counter #(.WIDTH(16)) u_third (
        .clock(clock),
        .srst(srst),
        .inc(third_event),
        .clr(clear_counters_q),
        .count(third_fail_count)
    );

    // Busy after each frame for the hold time, or while the core works
    always_ff @(posedge clock) begin
        if (srst) begin
            hold_q <= 8'h00;
            busy_q <= 1'b1;
        end else begin
            if (frame_end) begin
                hold_q <= 8'(HOLD_CYCLES);
            end else if (hold_q != 8'h00) begin
                hold_q <= hold_q - 8'h01;
            end
            busy_q <= core_busy || frame_end
                   || (hold_q > 8'h01); // [RL18] [RL22]
        end
    end

    assign busy = busy_q;
endmodule // radio_status_query

// file: logic/spi_byte_link.sv
// Serial slave byte engine: syncs the host pins, shifts bytes in and out.
// Assumes mode 0 (sample on rising, change on falling), MSB first.
`timescale 1ns/10ps
module spi_byte_link (
    input wire logic clock,
    input wire logic srst,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic chip_select_n,
    input wire logic [7:0] tx_byte,
    output logic frame_start,
    output logic frame_end,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic miso,
    output logic miso_oe
);
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic sclk_prev_q;
    logic sel_prev_q;
    logic [7:0] rx_sh_q;
    logic [7:0] tx_sh_q;
    logic [2:0] bit_q;
    logic start_q;
    logic end_q;
    logic valid_q;
    logic [7:0] byte_q;
    logic oe_q;

    // Synchronised pins: sclk, mosi, chip select active
    wire sclk_s = sync_q[2];
    wire mosi_s = sync_q[1];
    wire sel_s = sync_q[0];
    wire rise = sel_s && sclk_s && !sclk_prev_q;
    wire fall = sel_s && !sclk_s && sclk_prev_q;
    wire sel_on = sel_s && !sel_prev_q;
    wire sel_off = !sel_s && sel_prev_q;
    wire [7:0] rx_next = {rx_sh_q[6:0], mosi_s};

    assign frame_start = start_q;
    assign frame_end = end_q;
    assign rx_valid = valid_q;
    assign rx_byte = byte_q;
    assign miso = tx_sh_q[7];
    assign miso_oe = oe_q;

    // Two-stage synchronisers
    always_ff @(posedge clock) begin
        if (srst) begin
            meta_q <= 3'h0;
            sync_q <= 3'h0;
        end else begin
            meta_q <= {sclk, mosi, !chip_select_n};
            sync_q <= meta_q;
        end
    end

    // Edge detection, frame events and the byte shifters
    always_ff @(posedge clock) begin
        if (srst) begin
            sclk_prev_q <= 1'b0;
            sel_prev_q <= 1'b0;
            rx_sh_q <= 8'h00;
            tx_sh_q <= 8'h00;
            bit_q <= 3'h0;
            start_q <= 1'b0;
            end_q <= 1'b0;
            valid_q <= 1'b0;
            byte_q <= 8'h00;
            oe_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
            sel_prev_q <= sel_s;
            start_q <= sel_on;
            end_q <= sel_off;
            valid_q <= rise && (bit_q == 3'h7);
            oe_q <= sel_s;
            if (sel_on) begin
                bit_q <= 3'h0;
                tx_sh_q <= tx_byte; // First bit out before first edge
            end else if (rise) begin
                rx_sh_q <= rx_next;
                bit_q <= bit_q + 3'h1;
                if (bit_q == 3'h7) begin
                    byte_q <= rx_next;
                end
            end else if (fall) begin
                // New byte after the eighth bit, otherwise shift on
                tx_sh_q <= (bit_q == 3'h0) ? tx_byte
                         : {tx_sh_q[6:0], 1'b0};
            end
        end
    end
endmodule // spi_byte_link

// file: logic/stat_counter.sv
// Saturating event counter with a synchronous clear.
// Assumes increment and clear come from logic on the same clock.
`timescale 1ns/10ps
module stat_counter #(
    parameter int WIDTH = 16
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic inc,
    input wire logic clr,
    output logic [WIDTH-1:0] count
);
    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;
    wire at_max = &count_q;

    // An event in the clear cycle is kept: it counts as the first
    assign count_d = clr ? (inc ? WIDTH'(1) : '0)
                   : (inc && !at_max) ? count_q + WIDTH'(1) : count_q;
    assign count = count_q;

    // Count register
    always_ff @(posedge clock) begin
        if (srst) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end
endmodule // stat_counter
